/* design/cx_exec.sv */
// execute unit for multiply, negate, stack, relative call, reset and irq return
// Summary of operation
// RQ1: multiply working reg by file, 16-bit product into product high and low
// RQ2: multiply keeps operands and all status flags unchanged
// RQ3: bank bit 0 uses access bank, 1 uses bank select register
// RQ4: negate writes two's complement back to file, updates N OV C DC Z
// RQ5: stack pop drops top of stack in one cycle, no flags
// RQ6: stack push places instruction address plus 2 on stack, no flags
// RQ7: relative call target is address plus 2 plus twice signed offset
// RQ8: relative call pushes return address, loads target, second cycle idle
// RQ9: soft reset restores every master clear register and flag
// RQ10: irq return pops stack into program counter, two cycles
// RQ11: irq return sets high or low priority global enable
// RQ12: fast bit restores working, status and bank from shadow copies
// RQ13: irq return leaves program counter latches untouched
module cx_exec
   import cx_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic INSN_VALID,
   input wire logic [15:0] INSN,
   input wire logic [cx_pkg::ADDR_W-1:0] INSN_PC,
   output logic READY,
   output logic [cx_pkg::FADDR_W-1:0] FILE_ADDR,
   input wire logic [7:0] FILE_RDATA,
   output logic FILE_WE,
   output logic [cx_pkg::FADDR_W-1:0] FILE_WADDR,
   output logic [7:0] FILE_WDATA,
   input wire logic [cx_pkg::ADDR_W-1:0] TOP_OF_STACK,
   output logic STACK_PUSH,
   output logic [cx_pkg::ADDR_W-1:0] STACK_PUSH_DATA,
   output logic STACK_POP,
   output logic PC_LOAD,
   output logic [cx_pkg::ADDR_W-1:0] PC_TARGET,
   input wire logic PRIO_ENABLE,
   input wire logic IRQ_ENTER_HIGH,
   input wire logic IRQ_ENTER_LOW,
   input wire logic [7:0] SHADOW_WORKING,
   input wire logic [4:0] SHADOW_STATUS,
   input wire logic [3:0] SHADOW_BANK_SELECT,
   output logic [7:0] WORKING_REG,
   output logic [4:0] STATUS_REG,
   output logic [3:0] BANK_SELECT_REG,
   output logic [7:0] PRODUCT_HIGH,
   output logic [7:0] PRODUCT_LOW,
   output logic HIGH_PRIO_GLOBAL_ENABLE,
   output logic LOW_PRIO_GLOBAL_ENABLE,
   output logic SOFT_RESET
);
   import cx_pkg::*;

   cx_state_t state;
   logic [15:0] product;
   logic take;
   logic is_mul, is_neg, is_pop, is_push, is_call, is_ret, is_rst;
   logic bank_bit;
   logic [7:0] neg_res;
   logic [4:0] neg_flags;
   logic [ADDR_W-1:0] ret_addr;
   logic [ADDR_W-1:0] call_offset;
   logic [ADDR_W-1:0] call_target;
   logic [ADDR_W-1:0] held_target;
   logic held_target_valid;
   logic set_high, set_low;

   // instruction decode
   assign READY = (state == CX_EXEC);
   assign take = INSN_VALID && READY;
   assign is_mul = take && (INSN[15:9] == OPC_MUL_FILE);
   assign is_neg = take && (INSN[15:9] == OPC_NEG_FILE);
   assign is_call = take && (INSN[15:11] == OPC_REL_CALL);
   assign is_ret = take && (INSN[15:1] == OPC_RET_IRQ);
   assign is_pop = take && (INSN == OPC_STACK_POP);
   assign is_push = take && (INSN == OPC_STACK_PUSH);
   assign is_rst = take && (INSN == OPC_SOFT_RESET);

   // file operand address with access bank override
   assign bank_bit = INSN[8];
   assign FILE_ADDR = bank_bit ? {BANK_SELECT_REG, INSN[7:0]} : // RQ3
      (INSN[7] ? {ACCESS_HIGH_BANK, INSN[7:0]} : {4'h0, INSN[7:0]}); // RQ3

   // unsigned product of working register and file operand
   cx_mul8 u_mul (
      .A(WORKING_REG),
      .B(FILE_RDATA),
      .P(product)
   );

   // negation and its flags: carry and digit carry come from ~f + 1
   assign neg_res = 8'(~FILE_RDATA + 8'h01); // RQ4
   assign neg_flags[ST_C] = (FILE_RDATA == 8'h00);
   assign neg_flags[ST_DC] = (FILE_RDATA[3:0] == 4'h0);
   assign neg_flags[ST_Z] = (neg_res == 8'h00);
   assign neg_flags[ST_OV] = (FILE_RDATA == 8'h80);
   assign neg_flags[ST_N] = neg_res[7];

   // return address and relative call target
   assign ret_addr = ADDR_W'(INSN_PC + INSN_STEP); // RQ6
   assign call_offset = {{(ADDR_W - 12){INSN[10]}}, INSN[10:0], 1'b0};
   assign call_target = ADDR_W'(ret_addr + call_offset); // RQ7

   // which global enable an irq return sets
   assign set_high = is_ret && (!PRIO_ENABLE || !HIGH_PRIO_GLOBAL_ENABLE); // RQ11
   assign set_low = is_ret && PRIO_ENABLE && HIGH_PRIO_GLOBAL_ENABLE; // RQ11

   // sequencer for the two-cycle instructions
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= CX_EXEC;
      end else begin
         case (state)
            CX_EXEC: begin
               if (is_call || is_ret) begin // RQ8
                  state <= CX_SECOND;
               end
            end
            CX_SECOND: state <= CX_EXEC; // RQ10
            default: state <= CX_EXEC;
         endcase
      end
   end

   // call target held for the second cycle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         held_target <= '0;
      end else if (is_call) begin
         held_target <= call_target;
      end
   end

   // stack strobes and program counter load
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         STACK_PUSH <= 1'b0;
         STACK_PUSH_DATA <= '0;
         STACK_POP <= 1'b0;
         PC_LOAD <= 1'b0;
         PC_TARGET <= '0;
      end else begin
         STACK_PUSH <= is_push || is_call; // RQ6 RQ8
         STACK_POP <= is_pop || is_ret; // RQ5 RQ10
         PC_LOAD <= is_ret || (state == CX_SECOND && held_target_valid);
         if (is_push || is_call) begin
            STACK_PUSH_DATA <= ret_addr; // RQ6
         end
         if (is_ret) begin
            PC_TARGET <= TOP_OF_STACK; // RQ10 RQ13
         end else if (state == CX_SECOND && held_target_valid) begin
            PC_TARGET <= held_target; // RQ8
         end
      end
   end

   // marks that the second cycle belongs to a call, not a return
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         held_target_valid <= 1'b0;
      end else begin
         held_target_valid <= is_call;
      end
   end

   // file write-back of the negated operand
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         FILE_WE <= 1'b0;
         FILE_WADDR <= '0;
         FILE_WDATA <= 8'h00;
      end else begin
         FILE_WE <= is_neg; // RQ4
         if (is_neg) begin
            FILE_WADDR <= FILE_ADDR; // RQ4
            FILE_WDATA <= neg_res;
         end
      end
   end

   // core registers: working, status, bank select and product pair
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         WORKING_REG <= WORKING_RST;
         STATUS_REG <= STATUS_RST;
         BANK_SELECT_REG <= BANK_RST;
         PRODUCT_HIGH <= PRODUCT_RST;
         PRODUCT_LOW <= PRODUCT_RST;
      end else if (is_rst) begin
         WORKING_REG <= WORKING_RST; // RQ9
         STATUS_REG <= STATUS_RST;
         BANK_SELECT_REG <= BANK_RST;
         PRODUCT_HIGH <= PRODUCT_RST;
         PRODUCT_LOW <= PRODUCT_RST;
      end else begin
         if (is_mul) begin
            PRODUCT_HIGH <= product[15:8]; // RQ1
            PRODUCT_LOW <= product[7:0]; // RQ1
         end
         if (is_neg) begin
            STATUS_REG <= neg_flags; // RQ4
         end
         if (is_ret && INSN[0]) begin
            WORKING_REG <= SHADOW_WORKING; // RQ12
            STATUS_REG <= SHADOW_STATUS; // RQ12
            BANK_SELECT_REG <= SHADOW_BANK_SELECT; // RQ12
         end
      end
   end

   // global enables: irq entry clears, irq return sets and wins
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         HIGH_PRIO_GLOBAL_ENABLE <= 1'b0;
         LOW_PRIO_GLOBAL_ENABLE <= 1'b0;
      end else if (is_rst) begin
         HIGH_PRIO_GLOBAL_ENABLE <= 1'b0; // RQ9
         LOW_PRIO_GLOBAL_ENABLE <= 1'b0;
      end else begin
         if (set_high) begin
            HIGH_PRIO_GLOBAL_ENABLE <= 1'b1; // RQ11
         end else if (IRQ_ENTER_HIGH) begin
            HIGH_PRIO_GLOBAL_ENABLE <= 1'b0;
         end
         if (set_low) begin
            LOW_PRIO_GLOBAL_ENABLE <= 1'b1; // RQ11
         end else if (IRQ_ENTER_LOW) begin
            LOW_PRIO_GLOBAL_ENABLE <= 1'b0;
         end
      end
   end

   // soft reset strobe for neighbouring blocks
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SOFT_RESET <= 1'b0;
      end else begin
         SOFT_RESET <= is_rst; // RQ9
      end
   end

   // checks of the execution behaviour
   a_mul_product: assert property (@(posedge CLK) disable iff (!RESETN) // RQ1
      is_mul |=> {PRODUCT_HIGH, PRODUCT_LOW} == $past(WORKING_REG) * $past(FILE_RDATA))
      else $error("product pair wrong after multiply");
   a_mul_no_flags: assert property (@(posedge CLK) disable iff (!RESETN) // RQ2
      is_mul |=> $stable(STATUS_REG) && $stable(WORKING_REG) && !FILE_WE)
      else $error("multiply changed flags or operands");
   a_access_bank: assert property (@(posedge CLK) disable iff (!RESETN) // RQ3
      take && !INSN[8] |-> FILE_ADDR[11:8] == (INSN[7] ? ACCESS_HIGH_BANK : 4'h0))
      else $error("access bank not selected");
   a_bank_select: assert property (@(posedge CLK) disable iff (!RESETN) // RQ3
      take && INSN[8] |-> FILE_ADDR[11:8] == BANK_SELECT_REG)
      else $error("bank select not used");
   a_neg_write: assert property (@(posedge CLK) disable iff (!RESETN) // RQ4
      is_neg |=> FILE_WE && FILE_WDATA == 8'(8'h00 - $past(FILE_RDATA))
      && STATUS_REG[ST_Z] == (FILE_WDATA == 8'h00))
      else $error("negate result or zero flag wrong");
   a_pop_one: assert property (@(posedge CLK) disable iff (!RESETN) // RQ5
      is_pop ##1 (!is_pop && !is_ret) |-> (STACK_POP && !STACK_PUSH) ##1 !STACK_POP)
      else $error("pop strobe wrong");
   a_push_addr: assert property (@(posedge CLK) disable iff (!RESETN) // RQ6
      is_push |=> STACK_PUSH && STACK_PUSH_DATA == $past(INSN_PC) + INSN_STEP)
      else $error("push address wrong");
   a_call_seq: assert property (@(posedge CLK) disable iff (!RESETN) // RQ7 RQ8
      is_call |=> STACK_PUSH && !PC_LOAD && !READY ##1 PC_LOAD && READY
      && PC_TARGET == $past(call_target, 2))
      else $error("relative call sequence wrong");
   a_soft_reset: assert property (@(posedge CLK) disable iff (!RESETN) // RQ9
      is_rst |=> SOFT_RESET && WORKING_REG == WORKING_RST && STATUS_REG == STATUS_RST
      && !HIGH_PRIO_GLOBAL_ENABLE)
      else $error("soft reset incomplete");
   a_ret_seq: assert property (@(posedge CLK) disable iff (!RESETN) // RQ10 RQ13
      is_ret |=> STACK_POP && PC_LOAD && PC_TARGET == $past(TOP_OF_STACK) && !READY)
      else $error("irq return sequence wrong");
   a_ready_return: assert property (@(posedge CLK) disable iff (!RESETN) // RQ8 RQ10
      !READY |=> READY)
      else $error("second cycle not followed by ready");
   a_ret_enable: assert property (@(posedge CLK) disable iff (!RESETN) // RQ11
      is_ret |=> HIGH_PRIO_GLOBAL_ENABLE || LOW_PRIO_GLOBAL_ENABLE)
      else $error("irq return left interrupts off");
   a_entry_clear_high: assert property (@(posedge CLK) disable iff (!RESETN) // RQ11
      IRQ_ENTER_HIGH && !set_high && !is_rst |=> !HIGH_PRIO_GLOBAL_ENABLE)
      else $error("irq entry left high enable set");
   a_entry_clear_low: assert property (@(posedge CLK) disable iff (!RESETN) // RQ11
      IRQ_ENTER_LOW && !set_low && !is_rst |=> !LOW_PRIO_GLOBAL_ENABLE)
      else $error("irq entry left low enable set");
   a_ret_fast: assert property (@(posedge CLK) disable iff (!RESETN) // RQ12
      is_ret && INSN[0] |=> WORKING_REG == $past(SHADOW_WORKING)
      && BANK_SELECT_REG == $past(SHADOW_BANK_SELECT))
      else $error("shadow restore missing");
   a_ret_plain: assert property (@(posedge CLK) disable iff (!RESETN) // RQ12
      is_ret && !INSN[0] |=> $stable(WORKING_REG) && $stable(BANK_SELECT_REG))
      else $error("plain return touched registers");

   // scenarios worth seeing
   c_mul: cover property (@(posedge CLK) disable iff (!RESETN) is_mul);
   c_ret_vs_entry: cover property (@(posedge CLK) disable iff (!RESETN)
      is_ret && (IRQ_ENTER_HIGH || IRQ_ENTER_LOW));
   c_neg_zero: cover property (@(posedge CLK) disable iff (!RESETN)
      is_neg && FILE_RDATA == 8'h00);
   c_call: cover property (@(posedge CLK) disable iff (!RESETN) is_call ##2 is_ret);
   c_ret_fast: cover property (@(posedge CLK) disable iff (!RESETN) is_ret && INSN[0]);
endmodule

/* design/cx_mul8.sv */
// unsigned 8 by 8 multiplier, single cycle combinational
module cx_mul8 (
   input wire logic [7:0] A,
   input wire logic [7:0] B,
   output logic [15:0] P
);
   // full 16-bit product, never overflows
   assign P = 16'(A) * 16'(B);
endmodule

/* pkg/cx_pkg.sv */
// constants for the core instruction execute subset
package cx_pkg;
   localparam int ADDR_W = 21;
   localparam int FADDR_W = 12;
   // opcode patterns, matched on the top bits of the instruction word or, for pop, push and soft reset, on the whole word
   localparam logic [6:0] OPC_MUL_FILE = 7'h01; // insn[15:9]
   localparam logic [6:0] OPC_NEG_FILE = 7'h36; // insn[15:9]
   localparam logic [4:0] OPC_REL_CALL = 5'h1b; // insn[15:11]
   localparam logic [14:0] OPC_RET_IRQ = 15'h0008; // insn[15:1]
   localparam logic [15:0] OPC_STACK_POP = 16'h0006;
   localparam logic [15:0] OPC_STACK_PUSH = 16'h0005;
   localparam logic [15:0] OPC_SOFT_RESET = 16'h00ff;
   // status field positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_N = 4;
   // access bank split: low half at bank 0, high half at the top bank
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
   // values after reset
   localparam logic [7:0] WORKING_RST = 8'h00;
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [7:0] PRODUCT_RST = 8'h00;
   // the word address step of one instruction, in bytes
   localparam logic [20:0] INSN_STEP = 21'h000002;
   localparam int CALL_CYCLES = 2;
   localparam int RET_CYCLES = 2;
   typedef enum logic {CX_EXEC, CX_SECOND} cx_state_t;
endpackage

/* verif/cx_exec_test.sv */
// self-checking bench for the execute subset: hand-written irq returns first, then table rows, then more hand-written cases
module cx_exec_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cx_pkg::*;
   typedef struct packed {
      logic kind;
      logic [15:0] insn;
      logic [7:0] rdata;
      logic [11:0] addr;
      logic [15:0] res;
      logic [4:0] st;
   } cx_row_t;
   logic CLK, RESETN, INSN_VALID, READY, FILE_WE, STACK_PUSH, STACK_POP, PC_LOAD;
   logic PRIO_ENABLE, IRQ_ENTER_HIGH, IRQ_ENTER_LOW, SOFT_RESET;
   logic HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE;
   logic [15:0] INSN;
   logic [20:0] INSN_PC, TOP_OF_STACK, STACK_PUSH_DATA, PC_TARGET;
   logic [11:0] FILE_ADDR, FILE_WADDR;
   logic [7:0] FILE_RDATA, FILE_WDATA, SHADOW_WORKING, WORKING_REG, PRODUCT_HIGH, PRODUCT_LOW;
   logic [4:0] SHADOW_STATUS, STATUS_REG;
   logic [3:0] SHADOW_BANK_SELECT, BANK_SELECT_REG;
   int checks = 0;
   int fail_count = 0;
   int cycles = 0;
   cx_row_t rows [8];
   logic [20:0] cpc [2];
   logic [15:0] cop [2];
   logic [20:0] ctgt [2];
   cx_exec cx_exec_inst (.CLK(CLK), .RESETN(RESETN), .INSN_VALID(INSN_VALID), .INSN(INSN),
      .INSN_PC(INSN_PC), .READY(READY), .FILE_ADDR(FILE_ADDR), .FILE_RDATA(FILE_RDATA),
      .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
      .TOP_OF_STACK(TOP_OF_STACK), .STACK_PUSH(STACK_PUSH), .STACK_PUSH_DATA(STACK_PUSH_DATA),
      .STACK_POP(STACK_POP), .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET),
      .PRIO_ENABLE(PRIO_ENABLE), .IRQ_ENTER_HIGH(IRQ_ENTER_HIGH), .IRQ_ENTER_LOW(IRQ_ENTER_LOW),
      .SHADOW_WORKING(SHADOW_WORKING), .SHADOW_STATUS(SHADOW_STATUS),
      .SHADOW_BANK_SELECT(SHADOW_BANK_SELECT), .WORKING_REG(WORKING_REG),
      .STATUS_REG(STATUS_REG), .BANK_SELECT_REG(BANK_SELECT_REG), .PRODUCT_HIGH(PRODUCT_HIGH),
      .PRODUCT_LOW(PRODUCT_LOW), .HIGH_PRIO_GLOBAL_ENABLE(HIGH_PRIO_GLOBAL_ENABLE),
      .LOW_PRIO_GLOBAL_ENABLE(LOW_PRIO_GLOBAL_ENABLE), .SOFT_RESET(SOFT_RESET));
   // free-running 100 MHz clock
   initial CLK = 1'b0;
   always #5 CLK = ~CLK;
   // compare a single flag
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // compare a multi-bit value
   task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // counts and verdict, then stop
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // one instruction offered for one cycle; returns at the negedge after it was taken
   task automatic issue(input logic [15:0] op);
      @(negedge CLK);
      INSN_VALID = 1'b1;
      INSN = op;
      @(negedge CLK);
      INSN_VALID = 1'b0;
   endtask
   // core registers, strobes and global enables at their reset values, READY high
   task automatic rst_chk;
      chk_val({WORKING_REG, STATUS_REG, BANK_SELECT_REG, PRODUCT_HIGH, PRODUCT_LOW}, 40'h0);
      chk_val({FILE_WE, STACK_PUSH, STACK_POP, PC_LOAD, SOFT_RESET}, 40'h0);
      chk_val({HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE, READY}, 40'h1);
   endtask
   // hang guard
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 1000) begin
         fail_count++;
         wrap_up();
      end
   end
   // main sequence
   initial begin
      RESETN = 1'b0;
      INSN_VALID = 1'b0;
      INSN = 16'h0000;
      INSN_PC = 21'h000000;
      FILE_RDATA = 8'h00;
      TOP_OF_STACK = 21'h0abcde;
      PRIO_ENABLE = 1'b0;
      IRQ_ENTER_HIGH = 1'b0;
      IRQ_ENTER_LOW = 1'b0;
      SHADOW_WORKING = 8'hc4;
      SHADOW_STATUS = 5'h15;
      SHADOW_BANK_SELECT = 4'h3;
      // working reg c4, bank 3 after the fast return below
      rows = '{{1'b0, 16'h0320, 8'he2, 12'h320, 16'had08, 5'h15},
               {1'b0, 16'h0220, 8'hff, 12'h020, 16'hc33c, 5'h15},
               {1'b1, 16'h6d41, 8'h3a, 12'h341, 16'h00c6, 5'h10},
               {1'b0, 16'h0290, 8'h00, 12'hf90, 16'h0000, 5'h10},
               {1'b1, 16'h6c05, 8'h00, 12'h005, 16'h0000, 5'h07},
               {1'b1, 16'h6c85, 8'h80, 12'hf85, 16'h0080, 5'h1a},
               {1'b0, 16'h0301, 8'h01, 12'h301, 16'h00c4, 5'h1a},
               {1'b1, 16'h6dff, 8'h10, 12'h3ff, 16'h00f0, 5'h12}};
      cpc = '{21'h000100, 21'h001000};
      cop = '{16'hdc00, 16'hdbff};
      ctgt = '{21'h1ff902, 21'h001800};
      repeat (12) @(posedge CLK);
      rst_chk();
      @(negedge CLK);
      RESETN = 1'b1;
      issue(16'h0011);
      chk_val({STACK_POP, PC_LOAD, READY}, 40'h6);
      chk_val(PC_TARGET, 21'h0abcde);
      chk_bit(HIGH_PRIO_GLOBAL_ENABLE, 1'b1);
      chk_val({WORKING_REG, STATUS_REG, BANK_SELECT_REG}, {8'hc4, 5'h15, 4'h3});
      @(negedge CLK);
      chk_val({STACK_POP, PC_LOAD, READY}, 40'h1);
      PRIO_ENABLE = 1'b1;
      SHADOW_WORKING = 8'h99;
      SHADOW_STATUS = 5'h0a;
      SHADOW_BANK_SELECT = 4'h7;
      issue(16'h0010);
      chk_bit(LOW_PRIO_GLOBAL_ENABLE, 1'b1);
      chk_val({WORKING_REG, STATUS_REG, BANK_SELECT_REG}, {8'hc4, 5'h15, 4'h3});
      @(negedge CLK);
      IRQ_ENTER_HIGH = 1'b1;
      IRQ_ENTER_LOW = 1'b1;
      @(negedge CLK);
      IRQ_ENTER_HIGH = 1'b0;
      IRQ_ENTER_LOW = 1'b0;
      chk_val({HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE}, 40'h0);
      issue(16'h0010);
      chk_val({HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE}, 40'h2);
      @(negedge CLK);
      // back-to-back multiply and negate rows
      foreach (rows[i]) begin
         INSN_VALID = 1'b1;
         INSN = rows[i].insn;
         FILE_RDATA = rows[i].rdata;
         #1 chk_val(FILE_ADDR, rows[i].addr);
         @(negedge CLK);
         if (rows[i].kind) begin
            chk_val({FILE_WE, FILE_WADDR, FILE_WDATA}, {1'b1, rows[i].addr, rows[i].res[7:0]});
         end else begin
            chk_val({PRODUCT_HIGH, PRODUCT_LOW}, rows[i].res);
            chk_bit(FILE_WE, 1'b0);
         end
         chk_val({WORKING_REG, STATUS_REG}, {8'hc4, rows[i].st});
      end
      INSN_VALID = 1'b0;
      INSN_PC = 21'h000124;
      issue(16'h0005);
      chk_val({STACK_PUSH, STACK_PUSH_DATA, STATUS_REG}, {1'b1, 21'h000126, 5'h12});
      @(negedge CLK);
      chk_bit(STACK_PUSH, 1'b0);
      issue(16'h0006);
      chk_val({STACK_POP, PC_LOAD, STACK_PUSH, STATUS_REG}, {3'b100, 5'h12});
      // relative calls at both ends of the offset range
      for (int i = 0; i < 2; i++) begin
         INSN_PC = cpc[i];
         issue(cop[i]);
         chk_val({STACK_PUSH, STACK_PUSH_DATA, READY, PC_LOAD}, {1'b1, cpc[i] + 21'h2, 2'b00});
         @(negedge CLK);
         chk_val({PC_LOAD, PC_TARGET, READY, STACK_PUSH}, {1'b1, ctgt[i], 2'b10});
      end
      issue(16'h00ff);
      chk_bit(SOFT_RESET, 1'b1);
      chk_val({WORKING_REG, STATUS_REG, BANK_SELECT_REG, PRODUCT_HIGH, PRODUCT_LOW}, 40'h0);
      chk_val({HIGH_PRIO_GLOBAL_ENABLE, LOW_PRIO_GLOBAL_ENABLE}, 40'h0);
      @(negedge CLK);
      chk_bit(SOFT_RESET, 1'b0);
      // second reset in mid-run after a fast return loaded the registers
      issue(16'h0011);
      RESETN = 1'b0;
      #1 rst_chk();
      // release, then a fast return at the first edge against an irq entry
      @(negedge CLK);
      RESETN = 1'b1;
      INSN_VALID = 1'b1;
      IRQ_ENTER_HIGH = 1'b1;
      @(negedge CLK);
      INSN_VALID = 1'b0;
      IRQ_ENTER_HIGH = 1'b0;
      chk_val({STACK_POP, PC_LOAD, READY, HIGH_PRIO_GLOBAL_ENABLE}, 40'hd);
      chk_val({WORKING_REG, STATUS_REG, BANK_SELECT_REG}, {8'h99, 5'h0a, 4'h7});
      wrap_up();
   end
endmodule
